// File: include/dmac_consts.svh
// offsets, field positions, reset values and sizes of the dma channel engine
// assumes inclusion by bare name from package and design files
`ifndef DMAC_CONSTS_SVH
`define DMAC_CONSTS_SVH
// register port offsets
`define DMAC_REG_TABLE_BASE 8'h00
`define DMAC_REG_EN_SET 8'h04
`define DMAC_REG_EN_CLR 8'h08
`define DMAC_REG_BURST_SET 8'h0C
`define DMAC_REG_BURST_CLR 8'h10
`define DMAC_REG_ALT_STATUS 8'h14
`define DMAC_REG_ENGINE_STATUS 8'h18
// control table layout
`define DMAC_TABLE_ALIGN_BITS 10
`define DMAC_STRUCT_STRIDE 32'h0000_0010
`define DMAC_ALT_HALF 32'h0000_0200
`define DMAC_OFS_SRC_END 32'h0000_0000
`define DMAC_OFS_DST_END 32'h0000_0004
`define DMAC_OFS_CTRL 32'h0000_0008
// control word fields
`define DMAC_CW_MODE_LSB 0
`define DMAC_CW_MODE_MSB 2
`define DMAC_CW_BURST_BIT 3
`define DMAC_CW_CNT_LSB 4
`define DMAC_CW_CNT_MSB 14
`define DMAC_CW_ARB_LSB 15
`define DMAC_CW_ARB_MSB 18
`define DMAC_CW_SSIZE_LSB 24
`define DMAC_CW_SINC_LSB 26
`define DMAC_CW_DSIZE_LSB 28
`define DMAC_CW_DINC_LSB 30
// arbitration size limit as a power of two
`define DMAC_ARB_LOG_MAX 4'hA
`define DMAC_INC_NONE 2'h3
// reset values
`define DMAC_RST_WORD 32'h0000_0000
`endif

// File: include/dmac_pkg.sv
// types of the dma channel engine
// assumes dmac_consts.svh on the include path
`include "dmac_consts.svh"
package dmac_pkg;
   typedef enum logic [2:0] {
      DMAC_MODE_STOP = 3'h0,
      DMAC_MODE_BASIC = 3'h1,
      DMAC_MODE_AUTO = 3'h2,
      DMAC_MODE_PINGPONG = 3'h3
   } dmac_mode_e;

   typedef struct packed {
      logic req;
      logic we;
      logic [1:0] size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } dmac_mreq_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } dmac_reg_s;
endpackage : dmac_pkg

// File: logic/dmac_engine.sv
// dma channel engine: request handling, control table walk, transfer modes
// assumes one clock, memory slave answers each request with a one-cycle ack
`timescale 1ns/1ps
`default_nettype none
`include "dmac_consts.svh"
module dmac_engine
   import dmac_pkg::*;
#(
   parameter int NUM_CH = 32
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // peripheral requests
   input wire logic [NUM_CH-1:0] single_req,
   input wire logic [NUM_CH-1:0] burst_req,
   // memory master
   output dmac_mreq_s mem_out,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   // per-channel completion pulses
   output logic [NUM_CH-1:0] chan_done
);
   // refuse channel counts the 32-bit masks cannot serve
   if (NUM_CH < 1 || NUM_CH > 32) begin : g_bad_num_ch
      $error("dmac_engine: NUM_CH must be 1 to 32");
   end

   typedef enum {
      ST_IDLE,
      ST_RD_SRC,
      ST_RD_DST,
      ST_RD_CTL,
      ST_RD_DAT,
      ST_WR_DAT,
      ST_WB_CTL
   } dmac_state_e;

   // --------------------------------------------------------------
   // functions
   // --------------------------------------------------------------
   function automatic logic [4:0] dmac_first(input logic [31:0] v);
      logic [4:0] idx;
      idx = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (v[i]) begin
            idx = 5'(i);
         end
      end
      return idx;
   endfunction : dmac_first

   function automatic logic [31:0] dmac_item_addr(input logic [31:0] end_ptr,
      input logic [1:0] inc, input logic [10:0] cnt);
      logic [31:0] back;
      back = 32'({21'h0, cnt} - 32'h1);
      if (inc == `DMAC_INC_NONE) begin
         return end_ptr;
      end
      return end_ptr - (back << inc);
   endfunction : dmac_item_addr

   function automatic logic dmac_hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction : dmac_hit

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   dmac_state_e state_q, state_d;
   logic [31:0] base_q;
   logic [31:0] en_q, burst_only_q, alt_q, auto_run_q;
   logic [4:0] ch_q;
   logic [31:0] src_q, dst_q, ctl_q, dat_q;
   logic [10:0] cnt_q, bl_q;
   dmac_mreq_s mreq_q;
   logic [31:0] rdata_q, done_q;

   // --------------------------------------------------------------
   // register port decode
   // --------------------------------------------------------------
   wire logic [31:0] ch_mask = (NUM_CH == 32) ? 32'hFFFF_FFFF : ((32'h1 << NUM_CH) - 32'h1);
   wire logic hit_base = dmac_hit(reg_addr, `DMAC_REG_TABLE_BASE);
   wire logic hit_en_set = dmac_hit(reg_addr, `DMAC_REG_EN_SET);
   wire logic hit_en_clr = dmac_hit(reg_addr, `DMAC_REG_EN_CLR);
   wire logic hit_bo_set = dmac_hit(reg_addr, `DMAC_REG_BURST_SET);
   wire logic hit_bo_clr = dmac_hit(reg_addr, `DMAC_REG_BURST_CLR);
   wire logic hit_alt = dmac_hit(reg_addr, `DMAC_REG_ALT_STATUS);
   wire logic hit_stat = dmac_hit(reg_addr, `DMAC_REG_ENGINE_STATUS);
   wire logic wr_base = reg_wr && hit_base;
   wire logic [31:0] en_set = (reg_wr && hit_en_set) ? reg_wdata : 32'h0;
   wire logic [31:0] en_clr = (reg_wr && hit_en_clr) ? reg_wdata : 32'h0;
   wire logic [31:0] bo_set = (reg_wr && hit_bo_set) ? reg_wdata : 32'h0;
   wire logic [31:0] bo_clr = (reg_wr && hit_bo_clr) ? reg_wdata : 32'h0;
   wire logic [31:0] rd_mux =
      hit_base ? base_q :
      (hit_en_set || hit_en_clr) ? en_q :
      (hit_bo_set || hit_bo_clr) ? burst_only_q :
      hit_alt ? alt_q :
      hit_stat ? {23'h0, ch_q, 3'h0, state_q != ST_IDLE} :
      32'h0;

   // --------------------------------------------------------------
   // channel eligibility and selection
   // --------------------------------------------------------------
   wire logic [31:0] single_ok = {{(32-NUM_CH){1'b0}}, single_req} & ~burst_only_q;
   wire logic [31:0] breq = {{(32-NUM_CH){1'b0}}, burst_req};
   wire logic [31:0] elig = en_q & (breq | single_ok | auto_run_q);
   wire logic [4:0] pick = dmac_first(elig);
   wire logic ack_now = mreq_q.req && mem_ack;

   // --------------------------------------------------------------
   // control word fields
   // --------------------------------------------------------------
   wire logic [31:0] cw = (state_q == ST_RD_CTL) ? mem_rdata : ctl_q;
   wire logic [2:0] cw_mode = cw[`DMAC_CW_MODE_MSB:`DMAC_CW_MODE_LSB];
   wire logic [10:0] cw_cnt = cw[`DMAC_CW_CNT_MSB:`DMAC_CW_CNT_LSB];
   wire logic [3:0] cw_arb_raw = cw[`DMAC_CW_ARB_MSB:`DMAC_CW_ARB_LSB];
   wire logic [3:0] cw_arb = (cw_arb_raw > `DMAC_ARB_LOG_MAX) ? `DMAC_ARB_LOG_MAX : cw_arb_raw;
   wire logic [10:0] arb_items = 11'h1 << cw_arb;
   wire logic [1:0] s_size = ctl_q[`DMAC_CW_SSIZE_LSB+1:`DMAC_CW_SSIZE_LSB];
   wire logic [1:0] s_inc = ctl_q[`DMAC_CW_SINC_LSB+1:`DMAC_CW_SINC_LSB];
   wire logic [1:0] d_size = ctl_q[`DMAC_CW_DSIZE_LSB+1:`DMAC_CW_DSIZE_LSB];
   wire logic [1:0] d_inc = ctl_q[`DMAC_CW_DINC_LSB+1:`DMAC_CW_DINC_LSB];
   wire logic is_auto = cw_mode == 3'(DMAC_MODE_AUTO);
   wire logic is_pp = ctl_q[`DMAC_CW_MODE_MSB:`DMAC_CW_MODE_LSB] == 3'(DMAC_MODE_PINGPONG);
   wire logic use_burst = breq[ch_q] || auto_run_q[ch_q] || is_auto;
   wire logic [10:0] burst_len = (arb_items < cw_cnt) ? arb_items : cw_cnt;
   wire logic [10:0] first_len = use_burst ? burst_len : 11'h1;
   wire logic [10:0] cnt_dec = cnt_q - 11'h1;
   wire logic [2:0] wb_mode = (cnt_q == 11'h0) ? 3'(DMAC_MODE_STOP) :
      ctl_q[`DMAC_CW_MODE_MSB:`DMAC_CW_MODE_LSB];
   wire logic [31:0] wb_word = {ctl_q[31:`DMAC_CW_CNT_MSB+1], cnt_q, ctl_q[3], wb_mode};

   // --------------------------------------------------------------
   // table addressing
   // --------------------------------------------------------------
   wire logic [31:0] struct_base = {base_q[31:`DMAC_TABLE_ALIGN_BITS], 10'h000}
      + (alt_q[ch_q] ? `DMAC_ALT_HALF : 32'h0) + ({27'h0, ch_q} * `DMAC_STRUCT_STRIDE);
   wire logic [31:0] src_addr = dmac_item_addr(src_q, s_inc, cnt_q);
   wire logic [31:0] dst_addr = dmac_item_addr(dst_q, d_inc, cnt_q);

   // --------------------------------------------------------------
   // next state and memory request
   // --------------------------------------------------------------
   dmac_mreq_s mreq_d;
   always_comb begin
      state_d = state_q;
      mreq_d = mreq_q;
      if (ack_now) begin
         mreq_d.req = 1'b0;
      end
      case (state_q)
         ST_IDLE: begin
            if (elig != 32'h0) begin
               state_d = ST_RD_SRC;
            end
         end
         ST_RD_SRC: begin
            if (ack_now) begin
               state_d = ST_RD_DST;
            end else if (!mreq_q.req) begin
               mreq_d = '{1'b1, 1'b0, 2'h2, struct_base + `DMAC_OFS_SRC_END, 32'h0};
            end
         end
         ST_RD_DST: begin
            if (ack_now) begin
               state_d = ST_RD_CTL;
            end else if (!mreq_q.req) begin
               mreq_d = '{1'b1, 1'b0, 2'h2, struct_base + `DMAC_OFS_DST_END, 32'h0};
            end
         end
         ST_RD_CTL: begin
            if (ack_now) begin
               if (cw_mode == 3'(DMAC_MODE_STOP)) begin
                  state_d = ST_IDLE;
               end else if (cw_cnt == 11'h0) begin
                  state_d = ST_WB_CTL;
               end else begin
                  state_d = ST_RD_DAT;
               end
            end else if (!mreq_q.req) begin
               mreq_d = '{1'b1, 1'b0, 2'h2, struct_base + `DMAC_OFS_CTRL, 32'h0};
            end
         end
         ST_RD_DAT: begin
            if (ack_now) begin
               state_d = ST_WR_DAT;
            end else if (!mreq_q.req) begin
               mreq_d = '{1'b1, 1'b0, s_size, src_addr, 32'h0};
            end
         end
         ST_WR_DAT: begin
            if (ack_now) begin
               state_d = (bl_q == 11'h1 || cnt_q == 11'h1) ? ST_WB_CTL : ST_RD_DAT;
            end else if (!mreq_q.req) begin
               mreq_d = '{1'b1, 1'b1, d_size, dst_addr, dat_q};
            end
         end
         ST_WB_CTL: begin
            if (ack_now) begin
               state_d = ST_IDLE;
            end else if (!mreq_q.req) begin
               // only the control word is ever written back
               mreq_d = '{1'b1, 1'b1, 2'h2, struct_base + `DMAC_OFS_CTRL, wb_word};
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // --------------------------------------------------------------
   // per-channel hardware events
   // --------------------------------------------------------------
   wire logic [31:0] ch_bit = 32'h1 << ch_q;
   wire logic wb_done = state_q == ST_WB_CTL && ack_now;
   wire logic finish = wb_done && cnt_q == 11'h0;
   wire logic stop_seen = state_q == ST_RD_CTL && ack_now && cw_mode == 3'(DMAC_MODE_STOP);
   wire logic auto_start = state_q == ST_RD_CTL && ack_now && is_auto;
   wire logic [31:0] hw_dis = ((finish && !is_pp) || stop_seen) ? ch_bit : 32'h0;
   wire logic [31:0] pp_flip = (finish && is_pp) ? ch_bit : 32'h0;
   wire logic [31:0] done_d = finish ? ch_bit : 32'h0;
   // software set wins over a same-cycle hardware disable
   wire logic [31:0] en_d = ((en_q & ~en_clr & ~hw_dis) | en_set) & ch_mask;
   wire logic [31:0] bo_d = ((burst_only_q | bo_set) & ~bo_clr) & ch_mask;
   wire logic [31:0] auto_d = ((auto_run_q | (auto_start ? ch_bit : 32'h0))
      & ~(finish || stop_seen ? ch_bit : 32'h0)) & en_d;

   // --------------------------------------------------------------
   // registers
   // --------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         mreq_q <= '0;
         done_q <= `DMAC_RST_WORD;
         rdata_q <= `DMAC_RST_WORD;
      end else begin
         state_q <= state_d;
         mreq_q <= mreq_d;
         done_q <= done_d;
         rdata_q <= reg_rd ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         base_q <= `DMAC_RST_WORD;
         en_q <= `DMAC_RST_WORD;
         burst_only_q <= `DMAC_RST_WORD;
         alt_q <= `DMAC_RST_WORD;
         auto_run_q <= `DMAC_RST_WORD;
      end else begin
         if (wr_base) begin
            base_q <= {reg_wdata[31:`DMAC_TABLE_ALIGN_BITS], 10'h000};
         end
         en_q <= en_d;
         burst_only_q <= bo_d;
         alt_q <= alt_q ^ pp_flip;
         auto_run_q <= auto_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ch_q <= 5'h00;
         src_q <= `DMAC_RST_WORD;
         dst_q <= `DMAC_RST_WORD;
         ctl_q <= `DMAC_RST_WORD;
         dat_q <= `DMAC_RST_WORD;
         cnt_q <= 11'h0;
         bl_q <= 11'h0;
      end else begin
         if (state_q == ST_IDLE) begin
            ch_q <= pick;
         end
         if (state_q == ST_RD_SRC && ack_now) begin
            src_q <= mem_rdata;
         end
         if (state_q == ST_RD_DST && ack_now) begin
            dst_q <= mem_rdata;
         end
         if (state_q == ST_RD_CTL && ack_now) begin
            ctl_q <= mem_rdata;
            cnt_q <= cw_cnt;
            bl_q <= first_len;
         end
         if (state_q == ST_RD_DAT && ack_now) begin
            dat_q <= mem_rdata;
         end
         if (state_q == ST_WR_DAT && ack_now) begin
            cnt_q <= cnt_dec;
            bl_q <= bl_q - 11'h1;
         end
      end
   end

   // --------------------------------------------------------------
   // outputs
   // --------------------------------------------------------------
   assign reg_rdata = rdata_q;
   assign mem_out = mreq_q;
   assign chan_done = done_q[NUM_CH-1:0];
endmodule : dmac_engine
`default_nettype wire

// File: testbench/dmac_engine_properties.sv
// checker of the dma channel engine port behaviour
// assumes the top module ports only, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dmac_engine_properties
   import dmac_pkg::*;
#(
   parameter int NUM_CH = 32
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // requests and memory
   input wire logic [NUM_CH-1:0] single_req,
   input wire logic [NUM_CH-1:0] burst_req,
   input wire dmac_mreq_s mem_out,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   input wire logic [NUM_CH-1:0] chan_done
);
   // ------------------------------
   // table tracking
   // ------------------------------
   logic [31:0] base_q;
   logic ack_w;
   logic in_tab;
   logic ctrl_ack_w;
   assign ack_w = mem_ack && mem_out.req;
   assign in_tab = mem_out.addr[31:10] == base_q[31:10];
   assign ctrl_ack_w = ack_w && mem_out.we && in_tab;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         base_q <= 32'h0000_0000;
      end else if (reg_wr && reg_addr == 8'h00) begin
         base_q <= reg_wdata;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside read slot");
   a_req_steady: assert property (mem_out.req && !mem_ack |=> mem_out.req && $stable(mem_out))
      else $error("memory request changed before ack");
   a_idle_after_ack: assert property (ack_w |=> !mem_out.req)
      else $error("no idle cycle after ack");
   a_ptr_untouched: assert property (mem_out.req && mem_out.we && in_tab |-> mem_out.addr[3:0] == 4'h8)
      else $error("table write off the control word");
   a_struct_word: assert property (mem_out.req && in_tab |-> mem_out.addr[3:0] != 4'hC && mem_out.size == 2'h2)
      else $error("bad table access");
   a_done_onehot: assert property ($onehot0(chan_done))
      else $error("several done pulses at once");
   a_done_pulse: assert property (chan_done != 0 |=> chan_done == 0)
      else $error("done pulse too long");
   a_done_cause: assert property (chan_done != 0 |-> $past(ctrl_ack_w))
      else $error("done without control write back");
endmodule : dmac_engine_properties
bind dmac_engine dmac_engine_properties #(.NUM_CH(NUM_CH)) u_props (.sys_clk(sys_clk),
   .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .single_req(single_req), .burst_req(burst_req), .mem_out(mem_out),
   .mem_ack(mem_ack), .mem_rdata(mem_rdata), .chan_done(chan_done));
`default_nettype wire

// File: testbench/dmac_mem_model.sv
// memory slave model holding control table and data buffers
// assumes word accesses below 4 KiB, table at base 0
`timescale 1ns/1ps
`default_nettype none
module dmac_mem_model
   import dmac_pkg::*;
(
   // clock, reset, pacing
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic slow,
   // memory slave side
   input wire dmac_mreq_s mem_out,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   // ------------------------------
   // storage and answer
   // ------------------------------
   logic [31:0] mem [0:1023];
   logic [1:0] wait_q;
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         mem_ack <= 1'b0;
         wait_q <= 2'h0;
         mem_rdata <= 32'h0000_0000;
      end else if (mem_ack || !mem_out.req || (slow && wait_q != 2'h3)) begin
         mem_ack <= 1'b0;
         wait_q <= (mem_ack || !mem_out.req) ? 2'h0 : wait_q + 2'h1;
         mem_rdata <= ~mem_rdata;
      end else begin
         mem_ack <= 1'b1;
         if (mem_out.we) mem[mem_out.addr[11:2]] <= mem_out.wdata;
         else mem_rdata <= mem[mem_out.addr[11:2]];
      end
   end
endmodule : dmac_mem_model
`default_nettype wire

// File: testbench/dmac_engine_tb.sv
// self-checking bench of the dma channel engine
// assumes memory model and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
module dmac_engine_tb;
   import dmac_pkg::*;
   logic sys_clk, rst_n, reg_wr, reg_rd, mem_ack, slow;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, mem_rdata, chan_done, single_req, burst_req;
   dmac_mreq_s mem_out;
   int fails, n_checks, items, dones;
   logic [31:0] last_done;
   dmac_engine #(.NUM_CH(32)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .single_req(single_req), .burst_req(burst_req), .mem_out(mem_out), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .chan_done(chan_done));
   dmac_mem_model u_mem (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .mem_out(mem_out),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   // ------------------------------
   // clock, monitors, tasks
   // ------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (mem_ack && mem_out.req && mem_out.we && mem_out.addr >= 32'h0000_0400) items++;
      if (chan_done != 0) begin
         dones++;
         last_done = chan_done;
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(what, exp, reg_rdata);
   endtask : rd_chk
   function automatic logic [31:0] cw(dmac_mode_e md, logic [10:0] cnt, logic [3:0] arb);
      return {8'hAA, 5'h00, arb, cnt, 1'b0, md};
   endfunction : cw
   task automatic set_ch(input int alt, input int ch, input int cnt, input dmac_mode_e md,
         input logic [3:0] arb, input int src, input int dst);
      int t;
      t = alt * 128 + ch * 4;
      u_mem.mem[t] = src + 4 * (cnt - 1);
      u_mem.mem[t + 1] = dst + 4 * (cnt - 1);
      u_mem.mem[t + 2] = cw(md, 11'(cnt), arb);
      for (int i = 0; i < cnt; i++) u_mem.mem[src / 4 + i] = 32'h5A00_0000 + ch * 256 + i;
   endtask : set_ch
   task automatic copied(input int src, input int dst, input int n);
      for (int i = 0; i < n; i++) chk("dest", u_mem.mem[src / 4 + i], u_mem.mem[dst / 4 + i]);
   endtask : copied
   task automatic till(ref int cnt, input int tgt);
      for (int i = 0; i < 3000 && cnt < tgt; i++) @(posedge sys_clk);
   endtask : till
   task automatic print_verdict;
      if (fails == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   initial begin
      #200000;
      fails++;
      print_verdict();
   end
   // ------------------------------
   // scenarios
   // ------------------------------
   initial begin
      int n0, d0;
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, single_req, burst_req, slow} = '0;
      last_done = 32'h0;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd_chk(8'h04, 32'h0, "enable");
      wr(8'h00, 32'h0000_03FF);
      rd_chk(8'h00, 32'h0, "base");
      wr(8'h20, 32'hFFFF_FFFF);
      rd_chk(8'h20, 32'h0, "unmapped");
      wr(8'h0C, 32'h5);
      wr(8'h10, 32'h1);
      rd_chk(8'h0C, 32'h4, "burst_only");
      wr(8'h10, 32'h4);
      set_ch(0, 0, 5, DMAC_MODE_BASIC, 4'h1, 'h400, 'h800);
      n0 = items;
      d0 = dones;
      wr(8'h04, 32'h1);
      single_req[0] <= 1'b1;
      till(items, n0 + 1);
      single_req[0] <= 1'b0;
      repeat (40) @(posedge sys_clk);
      chk("single", n0 + 1, items);
      chk("ctrl", cw(DMAC_MODE_BASIC, 11'h4, 4'h1), u_mem.mem[2]);
      burst_req[0] <= 1'b1;
      till(items, n0 + 2);
      burst_req[0] <= 1'b0;
      repeat (40) @(posedge sys_clk);
      chk("burst", n0 + 3, items);
      chk("ctrl", cw(DMAC_MODE_BASIC, 11'h2, 4'h1), u_mem.mem[2]);
      burst_req[0] <= 1'b1;
      till(dones, d0 + 1);
      burst_req[0] <= 1'b0;
      repeat (10) @(posedge sys_clk);
      chk("items", n0 + 5, items);
      chk("ctrl_end", 32'h0, {17'h0, u_mem.mem[2][14:0]});
      copied('h400, 'h800, 5);
      chk("done_mask", 32'h1, last_done);
      rd_chk(8'h04, 32'h0, "auto_off");
      wr(8'h0C, 32'h2);
      set_ch(0, 1, 1, DMAC_MODE_BASIC, 4'h0, 'hC00, 'hC40);
      wr(8'h04, 32'h2);
      single_req[1] <= 1'b1;
      repeat (40) @(posedge sys_clk);
      chk("ignored", n0 + 5, items);
      burst_req[1] <= 1'b1;
      till(dones, d0 + 2);
      {single_req[1], burst_req[1]} <= 2'b00;
      chk("burst_won", n0 + 6, items);
      chk("done_mask1", 32'h2, last_done);
      set_ch(0, 2, 1, DMAC_MODE_STOP, 4'h0, 'hD00, 'hD40);
      wr(8'h04, 32'h4);
      single_req[2] <= 1'b1;
      repeat (40) @(posedge sys_clk);
      single_req[2] <= 1'b0;
      chk("stop", n0 + 6, items);
      chk("stop_done", d0 + 2, dones);
      rd_chk(8'h04, 32'h0, "stop_off");
      slow <= 1'b1;
      set_ch(0, 3, 4, DMAC_MODE_AUTO, 4'h0, 'hE00, 'hE40);
      wr(8'h04, 32'h8);
      single_req[3] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      single_req[3] <= 1'b0;
      till(dones, d0 + 3);
      slow <= 1'b0;
      chk("auto", n0 + 10, items);
      copied('hE00, 'hE40, 4);
      set_ch(0, 4, 1, DMAC_MODE_PINGPONG, 4'h0, 'hF00, 'hF40);
      set_ch(1, 4, 1, DMAC_MODE_PINGPONG, 4'h0, 'hF80, 'hFC0);
      wr(8'h04, 32'h10);
      burst_req[4] <= 1'b1;
      till(dones, d0 + 5);
      burst_req[4] <= 1'b0;
      wr(8'h08, 32'h10);
      repeat (20) @(posedge sys_clk);
      chk("switches", d0 + 5, dones);
      copied('hF00, 'hF40, 1);
      copied('hF80, 'hFC0, 1);
      chk("alt_ctrl", 32'h0, {17'h0, u_mem.mem[146][14:0]});
      rd_chk(8'h04, 32'h0, "cleared");
      chk("done_mask4", 32'h10, last_done);
      rd_chk(8'h18, 32'h0, "status_idle");
      print_verdict();
   end
endmodule : dmac_engine_tb
`default_nettype wire
